// *** nvr_regs.sv ***
// register bank of the flash/eeprom controller, axi4-lite slave
// assumes the flash array answers the security byte fetch with a one-cycle valid pulse
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module nvr_regs
(
	input  wire logic        CLK,             // bus clock, 50 MHz
	input  wire logic        RST,             // async reset, active high
	input  wire logic [17:0] S_AXI_AWADDR,    // write address
	input  wire logic        S_AXI_AWVALID,   // write address valid
	output logic             S_AXI_AWREADY,   // write address ready
	input  wire logic [31:0] S_AXI_WDATA,     // write data
	input  wire logic [3:0]  S_AXI_WSTRB,     // write strobes
	input  wire logic        S_AXI_WVALID,    // write data valid
	output logic             S_AXI_WREADY,    // write data ready
	output logic [1:0]       S_AXI_BRESP,     // write response
	output logic             S_AXI_BVALID,    // write response valid
	input  wire logic        S_AXI_BREADY,    // write response ready
	input  wire logic [17:0] S_AXI_ARADDR,    // read address
	input  wire logic        S_AXI_ARVALID,   // read address valid
	output logic             S_AXI_ARREADY,   // read address ready
	output logic [31:0]      S_AXI_RDATA,     // read data
	output logic [1:0]       S_AXI_RRESP,     // read response
	output logic             S_AXI_RVALID,    // read data valid
	input  wire logic        S_AXI_RREADY,    // read data ready
	output logic             SEC_FETCH_REQ,   // request security byte from flash
	output logic [17:0]      SEC_FETCH_ADDR,  // global address of that byte
	input  wire logic        SEC_FETCH_VALID, // fetched byte valid
	input  wire logic [7:0]  SEC_FETCH_DATA,  // fetched byte
	input  wire logic        BACKDOOR_UNLOCK, // pulse: backdoor key matched
	input  wire logic        CMD_DONE,        // pulse: sequencer finished a command
	input  wire logic [7:0]  FLASH_PROT_IN,   // flash protection state
	input  wire logic [7:0]  OPTION_IN,       // option byte state
	output logic             CMD_LAUNCH,      // pulse: command launched
	output logic [5:0]       DIVIDER_VALUE,   // divider for the ~1 MHz timebase
	output logic             KEY_ACCESS_EN,   // backdoor key access allowed
	output logic             DEVICE_SECURED   // device in secured state
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [7:0]  clock_divider_reg;
	logic [7:0]  security_reg;
	logic [7:0]  command_index_reg;
	logic [7:0]  config_reg;
	logic [7:0]  error_config_reg;
	logic [7:0]  status_reg;
	logic [7:0]  error_status_reg;
	logic [7:0]  eeprom_protect_reg;
	logic [7:0]  command_object_high;
	logic [7:0]  command_object_low;
	logic        backdoor_open;
	nvr_pkg::nvr_load_type load_state;

	logic        aw_held;
	logic        w_held;
	logic [15:0] aw_index;
	logic [7:0]  w_byte;
	logic        w_lane0;
	logic        do_write;
	logic        in_range_w;
	logic [15:0] ar_index;
	logic        in_range_r;
	logic [7:0]  next_rbyte;

	// ----------------------------------------------------------------
	// write channel: address and data taken in either order
	// ----------------------------------------------------------------
	assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
	assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
	assign do_write      = aw_held && w_held && !S_AXI_BVALID;
	assign in_range_w    = aw_index >= nvr_pkg::IDX_BASE && aw_index <= nvr_pkg::IDX_LAST;

	// capture address and data, raise the response once both are in
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_index     <= 16'h0000;
			w_byte       <= 8'h00;
			w_lane0      <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= nvr_pkg::RESP_OKAY;
		end
		else
		begin
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				aw_held  <= 1'b1;
				aw_index <= S_AXI_AWADDR[17:2];
			end
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				w_held  <= 1'b1;
				w_byte  <= S_AXI_WDATA[7:0];
				w_lane0 <= S_AXI_WSTRB[0];
			end
			if (do_write)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= in_range_w ? nvr_pkg::RESP_OKAY : nvr_pkg::RESP_SLVERR;
			end
			else if (S_AXI_BVALID && S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// plain read/write registers; unmapped slots drop writes
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			command_index_reg   <= nvr_pkg::RESET_ZERO;
			config_reg          <= nvr_pkg::RESET_ZERO;
			error_config_reg    <= nvr_pkg::RESET_ZERO;
			error_status_reg    <= nvr_pkg::RESET_ZERO;
			eeprom_protect_reg  <= nvr_pkg::RESET_ZERO;
			command_object_high <= nvr_pkg::RESET_ZERO;
			command_object_low  <= nvr_pkg::RESET_ZERO;
		end
		else if (do_write && w_lane0)
		begin
			// any index not listed here is left alone by this block
			unique case (aw_index)
				nvr_pkg::IDX_COMMAND_INDEX:  command_index_reg   <= w_byte;
				nvr_pkg::IDX_CONFIG:         config_reg          <= w_byte;
				nvr_pkg::IDX_ERROR_CONFIG:   error_config_reg    <= w_byte;
				nvr_pkg::IDX_ERROR_STATUS:   error_status_reg    <= w_byte;
				nvr_pkg::IDX_EEPROM_PROTECT: eeprom_protect_reg  <= w_byte;
				nvr_pkg::IDX_COMMAND_OBJ_HI: command_object_high <= w_byte;
				nvr_pkg::IDX_COMMAND_OBJ_LO: command_object_low  <= w_byte;
				default:                     ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// clock divider: loaded flag and sticky lock
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			clock_divider_reg <= nvr_pkg::RESET_ZERO;
		else if (do_write && w_lane0 && aw_index == nvr_pkg::IDX_CLOCK_DIVIDER)
		begin
			clock_divider_reg[nvr_pkg::DIV_LOADED_BIT] <= 1'b1;
			if (!clock_divider_reg[nvr_pkg::DIV_LOCK_BIT])
			begin
				// lock and value written together; once locked, nothing moves
				clock_divider_reg[nvr_pkg::DIV_LOCK_BIT] <= w_byte[nvr_pkg::DIV_LOCK_BIT];
				clock_divider_reg[5:0]                   <= w_byte[5:0];
			end
		end
	end
	assign DIVIDER_VALUE = clock_divider_reg[5:0];

	// ----------------------------------------------------------------
	// status: command complete flag, hardware set wins over launch clear
	// ----------------------------------------------------------------
	logic launch_write;
	assign launch_write = do_write && w_lane0 && aw_index == nvr_pkg::IDX_STATUS
		&& w_byte[nvr_pkg::STATUS_CCF_BIT] == 1'b0 && status_reg[nvr_pkg::STATUS_CCF_BIT];

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			status_reg <= nvr_pkg::RESET_STATUS;
			CMD_LAUNCH <= 1'b0;
		end
		else
		begin
			CMD_LAUNCH <= launch_write && !CMD_DONE;
			if (CMD_DONE)
				status_reg[nvr_pkg::STATUS_CCF_BIT] <= 1'b1;
			else if (launch_write)
				status_reg[nvr_pkg::STATUS_CCF_BIT] <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// security byte: fetched from flash after reset release
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			load_state    <= nvr_pkg::LOAD_WAIT;
			security_reg  <= nvr_pkg::RESET_ZERO;
			SEC_FETCH_REQ <= 1'b0;
		end
		else
		begin
			unique case (load_state)
				nvr_pkg::LOAD_WAIT:
				begin
					SEC_FETCH_REQ <= 1'b1;
					load_state    <= nvr_pkg::LOAD_REQ;
				end
				nvr_pkg::LOAD_REQ:
					if (SEC_FETCH_VALID)
					begin
						security_reg  <= SEC_FETCH_DATA;
						SEC_FETCH_REQ <= 1'b0;
						load_state    <= nvr_pkg::LOAD_DONE;
					end
				nvr_pkg::LOAD_DONE:
					; // no bus write path reaches security_reg
			endcase
		end
	end
	assign SEC_FETCH_ADDR = nvr_pkg::FLASH_SECURITY_ADDR;

	// backdoor unlock sticks until reset, only accepted when keys are enabled
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			backdoor_open <= 1'b0;
		else if (BACKDOOR_UNLOCK && KEY_ACCESS_EN)
			backdoor_open <= 1'b1;
	end

	logic [7:0] security_view;
	assign security_view  = backdoor_open
		? {security_reg[7:2], nvr_pkg::SEC_UNSECURED_CODE} : security_reg;
	assign KEY_ACCESS_EN  = security_reg[7:6] == nvr_pkg::KEY_ENABLED_CODE;
	assign DEVICE_SECURED = security_view[1:0] != nvr_pkg::SEC_UNSECURED_CODE;

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign ar_index      = S_AXI_ARADDR[17:2];
	assign in_range_r    = ar_index >= nvr_pkg::IDX_BASE && ar_index <= nvr_pkg::IDX_LAST;

	// read mux; empty slots read zero
	always_comb
	begin
		unique case (ar_index)
			nvr_pkg::IDX_CLOCK_DIVIDER:  next_rbyte = clock_divider_reg;
			nvr_pkg::IDX_SECURITY:       next_rbyte = security_view;
			nvr_pkg::IDX_COMMAND_INDEX:  next_rbyte = command_index_reg;
			nvr_pkg::IDX_CONFIG:         next_rbyte = config_reg;
			nvr_pkg::IDX_ERROR_CONFIG:   next_rbyte = error_config_reg;
			nvr_pkg::IDX_STATUS:         next_rbyte = status_reg;
			nvr_pkg::IDX_ERROR_STATUS:   next_rbyte = error_status_reg;
			nvr_pkg::IDX_FLASH_PROTECT:  next_rbyte = FLASH_PROT_IN;
			nvr_pkg::IDX_EEPROM_PROTECT: next_rbyte = eeprom_protect_reg;
			nvr_pkg::IDX_COMMAND_OBJ_HI: next_rbyte = command_object_high;
			nvr_pkg::IDX_COMMAND_OBJ_LO: next_rbyte = command_object_low;
			nvr_pkg::IDX_OPTION:         next_rbyte = OPTION_IN;
			default:                     next_rbyte = 8'h00;
		endcase
	end

	// one-cycle latency from address to data
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h00000000;
			S_AXI_RRESP  <= nvr_pkg::RESP_OKAY;
		end
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
		begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= {24'h000000, next_rbyte};
			S_AXI_RRESP  <= in_range_r ? nvr_pkg::RESP_OKAY : nvr_pkg::RESP_SLVERR;
		end
		else if (S_AXI_RREADY)
			S_AXI_RVALID <= 1'b0;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence div_write_s;
		do_write && w_lane0 && aw_index == nvr_pkg::IDX_CLOCK_DIVIDER;
	endsequence

	a_div_loaded_set: assert property (@(posedge CLK) disable iff (RST)
		div_write_s |=> clock_divider_reg[nvr_pkg::DIV_LOADED_BIT])
		else $error("divider loaded flag not set after write");
	a_div_loaded_hold: assert property (@(posedge CLK) disable iff (RST)
		clock_divider_reg[nvr_pkg::DIV_LOADED_BIT] |=> clock_divider_reg[nvr_pkg::DIV_LOADED_BIT])
		else $error("divider loaded flag fell without reset");
	a_div_lock_freeze: assert property (@(posedge CLK) disable iff (RST)
		clock_divider_reg[nvr_pkg::DIV_LOCK_BIT] |=> $stable(clock_divider_reg[6:0]))
		else $error("locked divider changed");
	a_sec_write_none: assert property (@(posedge CLK) disable iff (RST)
		load_state == nvr_pkg::LOAD_DONE |=> $stable(security_reg))
		else $error("security register changed after load");
	a_key_enable_dec: assert property (@(posedge CLK) disable iff (RST)
		KEY_ACCESS_EN == (security_reg[7] && !security_reg[6]))
		else $error("key enable decode wrong");
	a_backdoor_forces: assert property (@(posedge CLK) disable iff (RST)
		BACKDOOR_UNLOCK && KEY_ACCESS_EN |=> !DEVICE_SECURED)
		else $error("backdoor unlock did not unsecure");
	a_sec_state_dec: assert property (@(posedge CLK) disable iff (RST)
		!backdoor_open |-> DEVICE_SECURED == (security_reg[1:0] != 2'h2))
		else $error("secured decode wrong");
	a_empty_slot_zero: assert property (@(posedge CLK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY && ar_index == 16'h3023 |=> S_AXI_RDATA == 32'h0)
		else $error("empty slot read nonzero");
	a_sec_load_seq: assert property (@(posedge CLK) disable iff (RST)
		load_state == nvr_pkg::LOAD_REQ && SEC_FETCH_VALID
		|=> security_reg == $past(SEC_FETCH_DATA))
		else $error("security byte not captured");
	a_done_sets_ccf: assert property (@(posedge CLK) disable iff (RST)
		CMD_DONE |=> status_reg[nvr_pkg::STATUS_CCF_BIT])
		else $error("command complete not set");

endmodule

// *** nvr_pkg.sv ***
// package for the flash/eeprom controller register bank
// assumes an axi4-lite slave with 32-bit data, one register per aligned word
package nvr_pkg;

	// ----------------------------------------------------------------
	// register indices (printed offsets are not multiples of four)
	// ----------------------------------------------------------------
	localparam logic [15:0] IDX_BASE            = 16'h3020;
	localparam logic [15:0] IDX_LAST            = 16'h302f;
	localparam logic [15:0] IDX_CLOCK_DIVIDER   = 16'h3020;
	localparam logic [15:0] IDX_SECURITY        = 16'h3021;
	localparam logic [15:0] IDX_COMMAND_INDEX   = 16'h3022;
	localparam logic [15:0] IDX_CONFIG          = 16'h3024;
	localparam logic [15:0] IDX_ERROR_CONFIG    = 16'h3025;
	localparam logic [15:0] IDX_STATUS          = 16'h3026;
	localparam logic [15:0] IDX_ERROR_STATUS    = 16'h3027;
	localparam logic [15:0] IDX_FLASH_PROTECT   = 16'h3028;
	localparam logic [15:0] IDX_EEPROM_PROTECT  = 16'h3029;
	localparam logic [15:0] IDX_COMMAND_OBJ_HI  = 16'h302a;
	localparam logic [15:0] IDX_COMMAND_OBJ_LO  = 16'h302b;
	localparam logic [15:0] IDX_OPTION          = 16'h302c;
	localparam int          ADDR_WIDTH          = 18;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int          DIV_LOADED_BIT      = 7;
	localparam int          DIV_LOCK_BIT        = 6;
	localparam int          STATUS_CCF_BIT      = 7;
	localparam logic [7:0]  RESET_ZERO          = 8'h00;
	localparam logic [7:0]  RESET_STATUS        = 8'h80;
	localparam logic [1:0]  KEY_ENABLED_CODE    = 2'h2;
	localparam logic [1:0]  SEC_UNSECURED_CODE  = 2'h2;
	localparam logic [17:0] FLASH_SECURITY_ADDR = 18'h0ff7f;
	localparam logic [1:0]  RESP_OKAY           = 2'h0;
	localparam logic [1:0]  RESP_SLVERR         = 2'h2;

	typedef enum logic [2:0]
	{
		LOAD_WAIT = 3'b001,
		LOAD_REQ  = 3'b010,
		LOAD_DONE = 3'b100
	} nvr_load_type;

endpackage

// *** testbench.sv ***
// self-checking bench for the flash controller register bank
// assumes nvr_pkg and nvr_regs are compiled first; the bench drives every port itself
`timescale 1ns/1ps
module testbench;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, fetch_req, fetch_valid;
	logic        unlock, cmd_done, launch, key_en, secured;
	logic [17:0] awaddr, araddr, fetch_addr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [7:0]  fetch_data, prot_in, option_in, sec_exp;
	logic [5:0]  div_value;
	int          failures, comparisons, cycles, launches;
	int          mdl [16];

	nvr_regs DUT (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.SEC_FETCH_REQ(fetch_req), .SEC_FETCH_ADDR(fetch_addr),
		.SEC_FETCH_VALID(fetch_valid), .SEC_FETCH_DATA(fetch_data),
		.BACKDOOR_UNLOCK(unlock), .CMD_DONE(cmd_done), .FLASH_PROT_IN(prot_in),
		.OPTION_IN(option_in), .CMD_LAUNCH(launch), .DIVIDER_VALUE(div_value),
		.KEY_ACCESS_EN(key_en), .DEVICE_SECURED(secured));

	// ----------------------------------------------------------------
	// clock, launch counter and hang guard
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// a full run needs a few hundred cycles; the ceiling leaves ample margin
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (launch === 1'b1)
			launches <= launches + 1;
		if (cycles == 20000)
		begin
			failures++;
			results();
		end
	end

	// ----------------------------------------------------------------
	// model and shared tasks
	// ----------------------------------------------------------------
	function automatic void mwrite(input int i, input int d);
		if (i == 0)
		begin
			if ((mdl[0] & 'h40) == 0)
				mdl[0] = 'h80 | d;
		end
		else if (!(i inside {1, 3, 6, 8, 12, 13, 14, 15}))
			mdl[i] = d;
	endfunction

	function automatic logic [31:0] mread(input int i);
		if (i == 1)
			return {24'h0, sec_exp};
		if (i == 8)
			return {24'h0, prot_in};
		if (i == 12)
			return {24'h0, option_in};
		return 32'(mdl[i]);
	endfunction

	task automatic results;
		if (failures == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// address and data offered together; bready stays high so the answer is taken at once
	task automatic wr(input logic [15:0] idx, input logic [7:0] d, output logic [1:0] resp);
		logic ad;
		logic dd;
		ad = 1'b0;
		dd = 1'b0;
		awaddr <= {idx, 2'h0};
		wdata <= {24'($urandom()), d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && dd))
		begin
			@(posedge clk);
			if (!ad && awready === 1'b1)
			begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!dd && wready === 1'b1)
			begin
				dd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		resp = bresp;
	endtask

	task automatic rchk(input string what, input logic [15:0] idx, input logic [31:0] exp,
		input logic [1:0] er);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		chk(what, exp, rdata);
		chk({what, " resp"}, {30'h0, er}, {30'h0, rresp});
	endtask

	task automatic reset_dut;
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (mdl[i])
			mdl[i] = 0;
		mdl[6] = 'h80;
	endtask

	// ----------------------------------------------------------------
	// main sequence: one pass per backdoor key enable code
	// ----------------------------------------------------------------
	initial
	begin
		logic [1:0] r;
		logic [7:0] d;
		{rst, awvalid, wvalid, arvalid, fetch_valid, unlock, cmd_done} = 7'h40;
		{awaddr, araddr, wdata, fetch_data, cycles, launches} = '0;
		{bready, rready, wstrb} = 6'h3f;
		failures = 0;
		comparisons = 0;
		void'($urandom(1));
		prot_in = 8'($urandom());
		option_in = 8'($urandom());
		for (int k = 0; k < 4; k++)
		begin
			reset_dut();
			while (fetch_req !== 1'b1)
				@(posedge clk);
			chk("fetch addr", 32'h0000ff7f, {14'h0, fetch_addr});
			// key codes walk 00..11 while the state field walks 01,00,11,10
			sec_exp = {2'(k), 4'($urandom()), 2'(k) ^ 2'h1};
			fetch_valid <= 1'b1;
			fetch_data <= sec_exp;
			@(posedge clk);
			fetch_valid <= 1'b0;
			fetch_data <= ~sec_exp;
			repeat (2) @(posedge clk);
			chk("fetch req", 32'h0, {31'h0, fetch_req});
			for (int i = 0; i < 16; i++)
				rchk($sformatf("slot %0d", i), 16'h3020 + 16'(i), mread(i), 2'h0);
			chk("key enable", {31'h0, sec_exp[7:6] == 2'h2}, {31'h0, key_en});
			chk("secured", {31'h0, sec_exp[1:0] != 2'h2}, {31'h0, secured});
			wr(16'h3021, ~sec_exp, r);
			rchk("security kept", 16'h3021, mread(1), 2'h0);
			unlock <= 1'b1;
			@(posedge clk);
			unlock <= 1'b0;
			repeat (2) @(posedge clk);
			if (k == 2)
				sec_exp[1:0] = 2'h2;
			rchk("security unlocked", 16'h3021, mread(1), 2'h0);
			chk("secured after key", {31'h0, sec_exp[1:0] != 2'h2}, {31'h0, secured});
			// divider programmed only while no command runs; 0x31 gives about 1 MHz
			wr(16'h3020, 8'h31, r);
			chk("divider bresp", 32'h0, {30'h0, r});
			mwrite(0, 'h31);
			rchk("divider loaded", 16'h3020, mread(0), 2'h0);
			chk("divider out", 32'h31, {26'h0, div_value});
			for (int j = 0; j < 2; j++)
			begin
				d = j ? 8'h13 : 8'h4a;
				wr(16'h3020, d, r);
				mwrite(0, d);
				rchk("divider lock", 16'h3020, mread(0), 2'h0);
			end
			chk("divider frozen", 32'h0a, {26'h0, div_value});
			if (k == 0)
			begin
				for (int i = 1; i < 16; i++)
				begin
					d = 8'($urandom());
					if (i != 6)
						wr(16'h3020 + 16'(i), d, r);
					if (i != 6)
						mwrite(i, d);
				end
				wr(16'h301f, 8'h5a, r);
				chk("low range bresp", 32'h2, {30'h0, r});
				wr(16'h3030, 8'ha5, r);
				chk("high range bresp", 32'h2, {30'h0, r});
				rchk("out of range", 16'h3030, 32'h0, 2'h2);
				for (int i = 0; i < 16; i++)
					rchk($sformatf("slot %0d", i), 16'h3020 + 16'(i), mread(i), 2'h0);
				wr(16'h3026, 8'h00, r);
				repeat (2) @(posedge clk);
				chk("launches", 32'h1, 32'(launches));
				rchk("status busy", 16'h3026, mread(6) & 32'h7f, 2'h0);
				cmd_done <= 1'b1;
				@(posedge clk);
				cmd_done <= 1'b0;
				@(posedge clk);
				rchk("status done", 16'h3026, mread(6), 2'h0);
			end
		end
		results();
	end

endmodule
